// ==== rtl/ofrct_top.sv ====
// Read capture, delay tuning, busy polling and command engine reads of an octal flash controller
//
// Overview of operation
// (R01) PHY mode captures data on returned strobe
// (R02) Samples outside internal window are invalid
// (R03) Host tunes TX, RX and read delays
// (R04) Larger read delay moves sampling later
// (R05) Host enables pipeline mode for reads
// (R06) Host disables pipeline mode for writes
// (R07) Tuned mode disables hardware busy polling
// (R08) Host writes by DMA within pages
// (R09) Host polls busy between page writes
// (R10) Non-PHY writes may keep hardware polling
// (R11) Command engine reads request padding bytes
// (R12) Host right-shifts padded command data
// (R13) Host tunes first, retunes on failure
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module ofrct_top #(
	parameter int DLY_DEPTH = 16
) (
	// Clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Flash read return
	input  wire logic        strobe_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        busy_i,
	// Flash side control
	output logic             phy_en_o,
	output logic             pipe_mode_o,
	output logic [3:0]       tx_dly_o,
	output logic [3:0]       rx_dly_o,
	output logic             cmd_req_o,
	output logic [8:0]       cmd_len_o,
	// Captured read stream
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	output logic             rd_err_o
);

	localparam int DW = ofrct_pkg::DLY_W;
	localparam int CW = ofrct_pkg::CMD_CNT_W;

	typedef enum logic [1:0] {
		OFRCT_IDLE = 2'b01,
		OFRCT_READ = 2'b10
	} ofrct_cmd_e;

	// Register state
	logic                         phy_en_q;
	logic                         pipe_en_q;
	logic                         poll_en_q;
	logic [DW-1:0]                rd_dly_q;
	logic [DW-1:0]                tx_dly_q;
	logic [DW-1:0]                rx_dly_q;
	logic [ofrct_pkg::CMD_LEN_W-1:0] cmd_len_q;
	logic [ofrct_pkg::CMD_PAD_W-1:0] cmd_pad_q;
	logic [63:0]                  cmd_data_q;
	logic                         cap_err_q;
	logic                         cmd_done_q;
	ofrct_cmd_e                   cmd_state_q;
	logic [CW-1:0]                cmd_left_q;

	// Capture path
	logic                         strobe_prev_q;
	logic [8:0]                   cap_q;
	logic [8:0]                   dly_out;
	logic [ofrct_pkg::WIN_PH_W-1:0] phase_q;
	logic                         win_open;
	logic                         tuned;
	logic                         beat_ok;
	logic                         beat_bad;
	logic [7:0]                   pipe_data_q;
	logic                         pipe_vld_q;

	// Bus decode
	logic                         wr_ctrl;
	logic                         wr_dly;
	logic                         wr_clr;
	logic                         wr_cmd;
	logic                         cmd_start;
	logic [31:0]                  status;
	logic [31:0]                  rd_mux;

	assign wr_ctrl   = reg_wr_i && (reg_addr_i == ofrct_pkg::OFF_CTRL);
	assign wr_dly    = reg_wr_i && (reg_addr_i == ofrct_pkg::OFF_DELAY);
	assign wr_clr    = reg_wr_i && (reg_addr_i == ofrct_pkg::OFF_CLEAR);
	assign wr_cmd    = reg_wr_i && (reg_addr_i == ofrct_pkg::OFF_CMD);
	// A start while a command runs is dropped rather than restarting mid-transfer
	assign cmd_start = wr_cmd && reg_wdata_i[ofrct_pkg::CMD_START] && (cmd_state_q == OFRCT_IDLE);

	// Tuned mode: PHY capture with a non-zero read delay
	assign tuned = phy_en_q && (rd_dly_q != '0);

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			phy_en_q  <= ofrct_pkg::CTRL_RST[ofrct_pkg::CTRL_PHY_EN];
			pipe_en_q <= ofrct_pkg::CTRL_RST[ofrct_pkg::CTRL_PIPE_EN];
			poll_en_q <= ofrct_pkg::CTRL_RST[ofrct_pkg::CTRL_POLL_EN];
		end
		else if (ce_i && wr_ctrl)
		begin
			phy_en_q  <= reg_wdata_i[ofrct_pkg::CTRL_PHY_EN];
			pipe_en_q <= reg_wdata_i[ofrct_pkg::CTRL_PIPE_EN];
			poll_en_q <= reg_wdata_i[ofrct_pkg::CTRL_POLL_EN];
		end
	end

	// Delays are written as one set so tuning never sees a half-updated combination
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			rd_dly_q <= ofrct_pkg::DLY_RST;
			tx_dly_q <= ofrct_pkg::DLY_RST;
			rx_dly_q <= ofrct_pkg::DLY_RST;
		end
		else if (ce_i && wr_dly)
		begin
			rd_dly_q <= reg_wdata_i[ofrct_pkg::DLY_RD_LSB +: DW]; // see (R04)
			tx_dly_q <= reg_wdata_i[ofrct_pkg::DLY_TX_LSB +: DW]; // see (R03)
			rx_dly_q <= reg_wdata_i[ofrct_pkg::DLY_RX_LSB +: DW]; // see (R03)
		end
	end

	// Strobe edges of either polarity mark a data beat
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			strobe_prev_q <= 1'b0;
			cap_q         <= '0;
		end
		else if (ce_i)
		begin
			strobe_prev_q <= strobe_i;
			cap_q         <= {phy_en_q && (strobe_i != strobe_prev_q), data_i}; // see (R01)
		end
	end

	// Beats age by the read delay before meeting the internal window
	ofrct_tap_delay #(
		.W     (9),
		.DEPTH (DLY_DEPTH),
		.SW    (DW)
	) u_tap (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.ce_i       (ce_i),
		.din_i      (cap_q),
		.sel_i      (rd_dly_q), // see (R04)
		.dout_o     (dly_out)
	);

	// Free-running internal clock phase defines the window
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			phase_q <= '0;
		else if (ce_i)
			phase_q <= (phase_q == ofrct_pkg::WIN_PH_W'(ofrct_pkg::WIN_PERIOD - 1)) ? '0 : phase_q + 1'b1;
	end

	assign win_open = (phase_q < ofrct_pkg::WIN_PH_W'(ofrct_pkg::WIN_LEN));
	// Without the pipeline stage a delayed beat misses the output timing
	assign beat_ok  = dly_out[8] && win_open && (pipe_en_q || !tuned); // see (R02)
	assign beat_bad = dly_out[8] && !beat_ok; // see (R02)

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			pipe_data_q <= '0;
			pipe_vld_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			pipe_data_q <= dly_out[7:0];
			pipe_vld_q  <= beat_ok;
		end
	end

	// Pipeline mode adds one register stage to read data and valid; rd_err_o is not delayed
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			rd_data_o  <= '0;
			rd_valid_o <= 1'b0;
			rd_err_o   <= 1'b0;
		end
		else if (ce_i)
		begin
			rd_data_o  <= pipe_en_q ? pipe_data_q : dly_out[7:0]; // see (R05)
			rd_valid_o <= pipe_en_q ? pipe_vld_q : beat_ok;
			rd_err_o   <= beat_bad;
		end
	end

	// Sticky capture error; a new error beats a clear in the same cycle
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cap_err_q <= 1'b0;
		else if (ce_i)
		begin
			if (beat_bad)
				cap_err_q <= 1'b1; // see (R02)
			else if (wr_clr && reg_wdata_i[ofrct_pkg::ST_CAP_ERR])
				cap_err_q <= 1'b0; // see (R13)
		end
	end

	// Command engine read: length plus padding bytes from the flash
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			cmd_len_q <= '0;
			cmd_pad_q <= '0;
		end
		else if (ce_i && wr_cmd && (cmd_state_q == OFRCT_IDLE))
		begin
			cmd_len_q <= reg_wdata_i[ofrct_pkg::CMD_LEN_LSB +: ofrct_pkg::CMD_LEN_W];
			cmd_pad_q <= reg_wdata_i[ofrct_pkg::CMD_PAD_LSB +: ofrct_pkg::CMD_PAD_W]; // see (R11)
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			cmd_state_q <= OFRCT_IDLE;
			cmd_left_q  <= '0;
			cmd_req_o   <= 1'b0;
			cmd_len_o   <= '0;
		end
		else if (ce_i)
		begin
			cmd_req_o <= 1'b0;
			unique case (cmd_state_q)
				OFRCT_IDLE:
				begin
					if (cmd_start)
					begin
						cmd_left_q  <= CW'(reg_wdata_i[ofrct_pkg::CMD_LEN_LSB +: ofrct_pkg::CMD_LEN_W])
						             + CW'(reg_wdata_i[ofrct_pkg::CMD_PAD_LSB +: ofrct_pkg::CMD_PAD_W]); // see (R11)
						cmd_len_o   <= CW'(reg_wdata_i[ofrct_pkg::CMD_LEN_LSB +: ofrct_pkg::CMD_LEN_W])
						             + CW'(reg_wdata_i[ofrct_pkg::CMD_PAD_LSB +: ofrct_pkg::CMD_PAD_W]); // see (R11)
						cmd_req_o   <= 1'b1;
						cmd_state_q <= OFRCT_READ;
					end
				end
				OFRCT_READ:
				begin
					if (cmd_left_q == '0)
						cmd_state_q <= OFRCT_IDLE;
					else if (rd_valid_o)
					begin
						cmd_left_q <= cmd_left_q - 1'b1;
						if (cmd_left_q == CW'(1))
							cmd_state_q <= OFRCT_IDLE;
					end
				end
				default:
					cmd_state_q <= OFRCT_IDLE;
			endcase
		end
	end

	// Bytes shift in from the top; the host realigns by right-shifting
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cmd_data_q <= '0;
		else if (ce_i)
		begin
			if (cmd_start)
				cmd_data_q <= '0;
			else if ((cmd_state_q == OFRCT_READ) && rd_valid_o && (cmd_left_q != '0))
				cmd_data_q <= {rd_data_o, cmd_data_q[63:8]}; // see (R12)
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cmd_done_q <= 1'b0;
		else if (ce_i)
		begin
			if ((cmd_state_q == OFRCT_READ) && ((cmd_left_q == '0) || (rd_valid_o && (cmd_left_q == CW'(1)))))
				cmd_done_q <= 1'b1;
			else if (cmd_start || (wr_clr && reg_wdata_i[ofrct_pkg::ST_CMD_DONE]))
				cmd_done_q <= 1'b0;
		end
	end

	// Hardware polling reports nothing in tuned mode; software reads the raw bit
	always_comb
	begin
		status = '0;
		status[ofrct_pkg::ST_BUSY_RAW] = busy_i; // see (R09)
		status[ofrct_pkg::ST_BUSY_HW]  = poll_en_q && !tuned && busy_i; // see (R07) see (R10)
		status[ofrct_pkg::ST_POLL_OFF] = tuned; // see (R07)
		status[ofrct_pkg::ST_CAP_ERR]  = cap_err_q;
		status[ofrct_pkg::ST_CMD_BUSY] = (cmd_state_q == OFRCT_READ);
		status[ofrct_pkg::ST_CMD_DONE] = cmd_done_q;
	end

	always_comb
	begin
		rd_mux = '0;
		unique case (reg_addr_i)
			ofrct_pkg::OFF_CTRL:
			begin
				rd_mux[ofrct_pkg::CTRL_PHY_EN]  = phy_en_q;
				rd_mux[ofrct_pkg::CTRL_PIPE_EN] = pipe_en_q;
				rd_mux[ofrct_pkg::CTRL_POLL_EN] = poll_en_q;
			end
			ofrct_pkg::OFF_DELAY:
			begin
				rd_mux[ofrct_pkg::DLY_RD_LSB +: DW] = rd_dly_q;
				rd_mux[ofrct_pkg::DLY_TX_LSB +: DW] = tx_dly_q;
				rd_mux[ofrct_pkg::DLY_RX_LSB +: DW] = rx_dly_q;
			end
			ofrct_pkg::OFF_STATUS:
				rd_mux = status;
			ofrct_pkg::OFF_CMD:
			begin
				rd_mux[ofrct_pkg::CMD_LEN_LSB +: ofrct_pkg::CMD_LEN_W] = cmd_len_q;
				rd_mux[ofrct_pkg::CMD_PAD_LSB +: ofrct_pkg::CMD_PAD_W] = cmd_pad_q;
			end
			ofrct_pkg::OFF_CMD_LO:
				rd_mux = cmd_data_q[31:0];
			ofrct_pkg::OFF_CMD_HI:
				rd_mux = cmd_data_q[63:32];
			default:
				rd_mux = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			reg_rdata_o <= '0;
		else if (ce_i)
			reg_rdata_o <= reg_rd_i ? rd_mux : '0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			phy_en_o    <= 1'b0;
			pipe_mode_o <= 1'b0;
			tx_dly_o    <= '0;
			rx_dly_o    <= '0;
		end
		else if (ce_i)
		begin
			phy_en_o    <= phy_en_q;
			pipe_mode_o <= pipe_en_q; // see (R06)
			tx_dly_o    <= tx_dly_q; // see (R03)
			rx_dly_o    <= rx_dly_q; // see (R03)
		end
	end

endmodule

// ==== rtl/ofrct_pkg.sv ====
// Package of register map, field positions and reset values for the read capture tuner
package ofrct_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_DELAY    = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_CLEAR    = 8'h0c;
	localparam logic [7:0] OFF_CMD      = 8'h10;
	localparam logic [7:0] OFF_CMD_LO   = 8'h14;
	localparam logic [7:0] OFF_CMD_HI   = 8'h18;

	// Control fields
	localparam int CTRL_PHY_EN   = 0;
	localparam int CTRL_PIPE_EN  = 1;
	localparam int CTRL_POLL_EN  = 2;

	// Delay fields, each four bits wide
	localparam int DLY_W         = 4;
	localparam int DLY_RD_LSB    = 0;
	localparam int DLY_TX_LSB    = 8;
	localparam int DLY_RX_LSB    = 16;

	// Status fields
	localparam int ST_BUSY_RAW   = 0;
	localparam int ST_BUSY_HW    = 1;
	localparam int ST_POLL_OFF   = 2;
	localparam int ST_CAP_ERR    = 3;
	localparam int ST_CMD_BUSY   = 4;
	localparam int ST_CMD_DONE   = 5;

	// Command fields
	localparam int CMD_LEN_LSB   = 0;
	localparam int CMD_LEN_W     = 8;
	localparam int CMD_PAD_LSB   = 8;
	localparam int CMD_PAD_W     = 4;
	localparam int CMD_START     = 16;
	localparam int CMD_CNT_W     = 9;

	// Internal sampling window
	localparam int WIN_PERIOD    = 4;
	localparam int WIN_LEN       = 2;
	localparam int WIN_PH_W      = 2;

	// Reset values
	localparam logic [2:0]       CTRL_RST  = 3'h0;
	localparam logic [DLY_W-1:0] DLY_RST   = 4'h0;

endpackage

// ==== rtl/ofrct_tap_delay.sv ====
// Selectable tap delay line for strobe-captured bytes
`timescale 1ns/1ps
module ofrct_tap_delay #(
	parameter int W     = 9,
	parameter int DEPTH = 16,
	parameter int SW    = 4
) (
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          ce_i,
	// Data
	input  wire logic [W-1:0]  din_i,
	input  wire logic [SW-1:0] sel_i,
	output logic      [W-1:0]  dout_o
);

	logic [W-1:0] taps_q [DEPTH];

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				taps_q[i] <= '0;
		end
		else if (ce_i)
		begin
			taps_q[0] <= din_i;
			for (int i = 1; i < DEPTH; i++)
				taps_q[i] <= taps_q[i-1];
		end
	end

	// Tap zero is already one register behind the capture stage
	assign dout_o = taps_q[sel_i];

endmodule

// ==== test/ofrct_top_monitor.sv ====
// Port checks for the read capture tuner
`timescale 1ns/1ps
module ofrct_chk #(
	parameter int DLY_DEPTH = 16
) (
	// Clock and reset
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	// Register port
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// Flash side
	input wire logic        busy_i,
	input wire logic        phy_en_o,
	input wire logic        cmd_req_o,
	input wire logic [8:0]  cmd_len_o,
	input wire logic        rd_valid_o,
	input wire logic        rd_err_o
);
	// Longest tap plus capture stages, with margin for beats in flight
	localparam int QUIET = DLY_DEPTH + 8;
	logic [5:0] off_q;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i || phy_en_o)
			off_q <= 6'h00;
		else if (off_q != 6'h3f)
			off_q <= off_q + 6'h01;
	end

	logic s_wr_ok;
	assign s_wr_ok = reg_wr_i && reg_addr_i == ofrct_pkg::OFF_CMD && reg_wdata_i[ofrct_pkg::CMD_START];

	sequence s_wr(a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	sequence s_st_rd;
		reg_rd_i && reg_addr_i == ofrct_pkg::OFF_STATUS;
	endsequence

	chk_ctrl_echo: assert property (s_wr(ofrct_pkg::OFF_CTRL) |-> ##2
		phy_en_o == $past(reg_wdata_i[0], 2))
		else $error("phy enable wrong");
	chk_no_beats: assert property (off_q >= QUIET |-> !rd_valid_o && !rd_err_o)
		else $error("beat while disabled");
	chk_busy_raw: assert property (s_st_rd |=> reg_rdata_o[0] == $past(busy_i))
		else $error("raw busy wrong");
	chk_poll_split: assert property (s_st_rd |=> !(reg_rdata_o[1] && reg_rdata_o[2])
		&& (reg_rdata_o[0] || !reg_rdata_o[1]))
		else $error("busy bits wrong");
	chk_cmd_cause: assert property ($rose(cmd_req_o) |-> $past(s_wr_ok))
		else $error("request without start");
	chk_cmd_len: assert property (cmd_req_o |->
		cmd_len_o == $past(reg_wdata_i[7:0]) + $past(reg_wdata_i[11:8]))
		else $error("length wrong");
	chk_cmd_pulse: assert property (cmd_req_o |=> !cmd_req_o)
		else $error("request too long");
	chk_len_hold: assert property (!cmd_req_o |-> $stable(cmd_len_o))
		else $error("length moved");
endmodule

bind ofrct_top ofrct_chk #(.DLY_DEPTH(DLY_DEPTH)) u_chk (
	.core_clk_i  (core_clk_i),
	.rst_b_i     (rst_b_i),
	.reg_addr_i  (reg_addr_i),
	.reg_wdata_i (reg_wdata_i),
	.reg_wr_i    (reg_wr_i),
	.reg_rd_i    (reg_rd_i),
	.reg_rdata_o (reg_rdata_o),
	.busy_i      (busy_i),
	.phy_en_o    (phy_en_o),
	.cmd_req_o   (cmd_req_o),
	.cmd_len_o   (cmd_len_o),
	.rd_valid_o  (rd_valid_o),
	.rd_err_o    (rd_err_o)
);

// ==== test/ofrct_flash_model.sv ====
// Flash model returning strobe-framed read bytes
`timescale 1ns/1ps
module ofrct_flash_model (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	// Frame requests
	input  wire logic       cmd_req_i,
	input  wire logic [8:0] cmd_len_i,
	input  wire logic       go_i,
	input  wire logic [1:0] off_i,
	input  wire logic       hold_busy_i,
	// Flash pins
	output logic            strobe_o,
	output logic [7:0]      data_o,
	output logic            busy_o
);
	logic [8:0] left_q;
	logic [7:0] idx_q;
	logic [2:0] wait_q;
	logic [2:0] gap_q;

	assign busy_o = hold_busy_i;

	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			left_q   <= 9'h000;
			wait_q   <= 3'h0;
			strobe_o <= 1'b0;
			data_o   <= 8'h00;
		end
		else if (left_q != 9'h000 && wait_q == 3'h0)
		begin
			strobe_o <= ~strobe_o;
			data_o   <= 8'ha0 + idx_q;
			idx_q    <= idx_q + 8'h01;
			left_q   <= left_q - 9'h001;
			wait_q   <= gap_q - 3'h1;
		end
		else
		begin
			// Idle bus flips each cycle so a stale byte never looks valid
			data_o <= ~data_o;
			if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
			else if (cmd_req_i)
			begin
				left_q <= cmd_len_i;
				idx_q  <= 8'h00;
				wait_q <= {1'b0, off_i};
				gap_q  <= 3'h4;
			end
			else if (go_i)
			begin
				left_q <= 9'h008;
				idx_q  <= 8'h00;
				gap_q  <= 3'h1;
			end
		end
	end
endmodule

// ==== test/test_octal_flash_read_capture_tuning.sv ====
// Self-checking bench for the read capture tuner
`timescale 1ns/1ps
module test_octal_flash_read_capture_tuning;
	logic        core_clk_i;
	logic        rst_b_i     = 1'b0;
	logic [7:0]  reg_addr_i  = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic        go          = 1'b0;
	logic        hold_busy   = 1'b0;
	logic [1:0]  off         = 2'h0;
	logic [1:0]  cyc         = 2'h0;
	logic [31:0] reg_rdata_o;
	logic        strobe_i;
	logic [7:0]  data_i;
	logic        busy_i;
	logic        cmd_req_o;
	logic [8:0]  cmd_len_o;
	logic [7:0]  rd_data_o;
	logic        rd_valid_o;
	logic        rd_err_o;
	logic        pipe_mode_o;
	logic [3:0]  tx_dly_o;
	logic [3:0]  rx_dly_o;
	logic [7:0]  mask;
	int          errs;
	int          fail_count  = 0;
	int          n_compared  = 0;

	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	ofrct_top dut (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.ce_i        (1'b1),
		.reg_addr_i  (reg_addr_i),
		.reg_wdata_i (reg_wdata_i),
		.reg_wr_i    (reg_wr_i),
		.reg_rd_i    (reg_rd_i),
		.reg_rdata_o (reg_rdata_o),
		.strobe_i    (strobe_i),
		.data_i      (data_i),
		.busy_i      (busy_i),
		.phy_en_o    (),
		.pipe_mode_o (pipe_mode_o),
		.tx_dly_o    (tx_dly_o),
		.rx_dly_o    (rx_dly_o),
		.cmd_req_o   (cmd_req_o),
		.cmd_len_o   (cmd_len_o),
		.rd_data_o   (rd_data_o),
		.rd_valid_o  (rd_valid_o),
		.rd_err_o    (rd_err_o)
	);

	ofrct_flash_model flash (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.cmd_req_i   (cmd_req_o),
		.cmd_len_i   (cmd_len_o),
		.go_i        (go),
		.off_i       (off),
		.hold_busy_i (hold_busy),
		.strobe_o    (strobe_i),
		.data_o      (data_i),
		.busy_o      (busy_i)
	);

	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 2'h1;
		// A new frame starts its own tally
		if (go)
		begin
			mask <= 8'h00;
			errs <= 0;
		end
		else
		begin
			if (rd_valid_o === 1'b1 && rd_data_o[7:3] === 5'h14)
				mask[rd_data_o[2:0]] <= 1'b1;
			if (rd_err_o === 1'b1)
				errs <= errs + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		// Read data stand in the cycle after the strobe only
		@(posedge core_clk_i);
		d = reg_rdata_o;
	endtask

	task automatic reset_dut;
		rst_b_i <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
	endtask

	// Frames start on the same window phase so results can be compared
	task automatic probe(output logic [7:0] m, output int e);
		@(posedge core_clk_i);
		while (cyc != 2'h0)
			@(posedge core_clk_i);
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		repeat (40) @(posedge core_clk_i);
		m = mask;
		e = errs;
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic [7:0]  m;
		int          e;
		rd(ofrct_pkg::OFF_CTRL, r);
		chk(r, 32'h0);
		wr(ofrct_pkg::OFF_DELAY, 32'h000f0a05);
		wr(ofrct_pkg::OFF_STATUS, 32'hffffffff);
		rd(ofrct_pkg::OFF_DELAY, r);
		chk(r, 32'h000f0a05);
		chk({24'h0, rx_dly_o, tx_dly_o}, 32'h000000fa);
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r, 32'h0);
		rd(8'h20, r);
		chk(r, 32'h0);
		probe(m, e);
		chk({24'h0, m}, 32'h0);
		chk(32'(e), 32'h0);
	endtask

	task automatic t_window;
		logic [7:0] m1;
		logic [7:0] m2;
		int         e1;
		int         e2;
		wr(ofrct_pkg::OFF_CTRL, 32'h3);
		wr(ofrct_pkg::OFF_DELAY, 32'h1);
		chk({31'h0, pipe_mode_o}, 32'h1);
		probe(m1, e1);
		wr(ofrct_pkg::OFF_DELAY, 32'h2);
		probe(m2, e2);
		chk(32'($countones(m1)), 32'd4);
		chk(32'(e1 + e2), 32'd8);
		chk({25'h0, m2[6:0]}, {25'h0, m1[7:1]});
	endtask

	task automatic t_no_pipe;
		logic [31:0] r;
		logic [7:0]  m;
		int          e;
		wr(ofrct_pkg::OFF_CTRL, 32'h1);
		probe(m, e);
		chk({31'h0, pipe_mode_o}, 32'h0);
		chk({24'h0, m}, 32'h0);
		chk(32'(e), 32'd8);
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r & 32'h8, 32'h8);
		wr(ofrct_pkg::OFF_CLEAR, 32'h8);
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r & 32'h8, 32'h0);
	endtask

	task automatic t_busy;
		logic [31:0] r;
		wr(ofrct_pkg::OFF_CTRL, 32'h5);
		hold_busy <= 1'b1;
		wr(ofrct_pkg::OFF_DELAY, 32'h0);
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r, 32'h3);
		wr(ofrct_pkg::OFF_DELAY, 32'h3);
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r, 32'h5);
		@(posedge core_clk_i);
		hold_busy <= 1'b0;
		// The next page write may only start once software sees busy drop
		rd(ofrct_pkg::OFF_STATUS, r);
		chk(r, 32'h4);
	endtask

	// A stalled command only leaves through reset, so each offset gets one
	task automatic t_cmd;
		logic [31:0] r;
		int          n;
		n = 0;
		for (int k = 0; k < 4; k++)
		begin
			reset_dut;
			off <= k[1:0];
			wr(ofrct_pkg::OFF_CTRL, 32'h1);
			wr(ofrct_pkg::OFF_CMD, 32'h00010102);
			r = 32'h0;
			for (int j = 0; j < 20 && r[5] !== 1'b1; j++)
				rd(ofrct_pkg::OFF_STATUS, r);
			if (r[5] === 1'b1)
			begin
				n++;
				rd(ofrct_pkg::OFF_CMD_HI, r);
				chk(r >> 8, 32'h00a2a1a0);
			end
		end
		chk(32'(n), 32'd2);
	endtask

	task automatic complete_run;
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#50000;
		fail_count++;
		complete_run;
	end

	initial
	begin
		reset_dut;
		t_regs;
		t_window;
		t_no_pipe;
		t_busy;
		t_cmd;
		complete_run;
	end
endmodule
